// ### aso_pkg.sv
// shared constants and carrier types for the converter serial output port
package aso_pkg;
  // ***************************************************
  // register indices (byte address is four times the index)
  // ***************************************************
  localparam logic [5:0] IDX_CLOCK_MULT = 6'h01;
  localparam logic [5:0] IDX_POWER_POL = 6'h04;
  localparam logic [5:0] IDX_FMT_MODE_RATE = 6'h05;
  localparam logic [5:0] IDX_FRAME_SLOT = 6'h06;
  localparam logic [5:0] IDX_MAP_LOW = 6'h07;
  localparam logic [5:0] IDX_MAP_HIGH = 6'h08;
  localparam logic [5:0] IDX_DRIVE_THERMAL = 6'h09;
  localparam logic [5:0] IDX_PORT_STATUS = 6'h1F;
  // reset values
  localparam logic [7:0] RST_CLOCK_MULT = 8'h01;
  localparam logic [7:0] RST_POWER_POL = 8'h3F;
  localparam logic [7:0] RST_FMT_MODE_RATE = 8'h02;
  localparam logic [7:0] RST_FRAME_SLOT = 8'h00;
  localparam logic [7:0] RST_MAP_LOW = 8'h10;
  localparam logic [7:0] RST_MAP_HIGH = 8'h32;
  localparam logic [7:0] RST_DRIVE_THERMAL = 8'hF0;
  // writable bits of the mixed drive / thermal register
  localparam logic [7:0] DRIVE_WR_MASK = 8'hF8;
  // ***************************************************
  // field codes
  // ***************************************************
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_RJ24 = 2'h2;
  localparam logic [1:0] FMT_RJ16 = 2'h3;
  localparam logic [2:0] MODE_STEREO = 3'h0;
  localparam logic [2:0] MODE_TDM2 = 3'h1;
  localparam logic [2:0] MODE_TDM4 = 3'h2;
  localparam logic [2:0] MODE_TDM8 = 3'h3;
  localparam logic [2:0] MODE_TDM16 = 3'h4;
  localparam logic [2:0] RATE_32_48 = 3'h2;
  localparam logic [2:0] RATE_128_192 = 3'h4;
  localparam logic [1:0] SLOTW_32 = 2'h0;
  localparam logic [1:0] SLOTW_24 = 2'h1;
  localparam logic [1:0] SLOTW_16 = 2'h2;
  localparam logic [5:0] LEN_32 = 6'h20;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [4:0] SLOTS_2 = 5'h02;
  localparam logic [4:0] SLOTS_4 = 5'h04;
  localparam logic [4:0] SLOTS_8 = 5'h08;
  localparam logic [4:0] SLOTS_16 = 5'h10;
  localparam logic [4:0] SLOT_NONE = 5'h1F;
  localparam logic [4:0] STEREO_B_OFS = 5'h02;
  localparam int SAMPLE_W = 24;
  // ***************************************************
  // bus answers and master bit clock timing
  // ***************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYS_PERIOD_NS = 50;
  localparam int BCLK_HALF_NS = 200;
  localparam logic [2:0] BCLK_HALF_CYC = 3'(BCLK_HALF_NS / SYS_PERIOD_NS);
  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic [3:0][SAMPLE_W-1:0] smp;
  } aso_samples_t;
  typedef struct packed {
    logic regulator;
    logic vref;
    logic [3:0] converter;
  } aso_power_t;
  typedef struct packed {
    logic refFrame;
    logic [2:0] ratioCode;
    logic [9:0] ratio;
    logic refSupported;
  } aso_pll_t;
endpackage : aso_pkg

// ### aso_serial_port.sv
// converter serial audio output port with its AXI4-Lite register file
`timescale 1ns/100ps
`default_nettype none
module aso_serial_port
  import aso_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite register port
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter samples and thermal flag
  input wire aso_samples_t samples,
  input wire logic overTemp,
  // bit clock and frame clock pins
  input wire logic bitClkIn,
  output logic bitClkOut,
  output logic bitClkOe_n,
  input wire logic frameClkIn,
  output logic frameClkOut,
  output logic frameClkOe_n,
  // serial data pins
  output logic serialOutA,
  output logic serialOutAOe_n,
  output logic serialOutB,
  output logic serialOutBOe_n,
  // block power and clock generator controls
  output aso_power_t power,
  output aso_pll_t pll,
  output logic [2:0] rateBand
);
  // ***************************************************
  // control registers
  // ***************************************************
  logic [7:0] regClock, regPower, regFmt, regFrame, regMapLo, regMapHi, regDrive;
  logic [7:0] next_regClock, next_regPower, next_regFmt, next_regFrame;
  logic [7:0] next_regMapLo, next_regMapHi, next_regDrive;
  logic [2:0] syncA, syncB, syncLast;
  logic awHeld, wHeld, bValid, rValid;
  logic [1:0] bResp, rResp;
  logic [7:0] awAddr, rData;
  logic [7:0] wData;
  logic wLane0;
  logic next_awHeld, next_wHeld, next_bValid, next_rValid;
  logic [1:0] next_bResp, next_rResp;
  logic [7:0] next_awAddr, next_wData, next_rData;
  logic next_wLane0;
  logic frameSeen;

  // field views
  logic [1:0] dataFormat;
  logic [2:0] portMode;
  logic tdmPinSelect, wordIs16, frameShape, bitOrder, clocksPerChannel;
  logic clockMasterSelect, frameClockPolarity, dataChangeEdge, unusedSlotFloat;
  logic [1:0] slotWidthCode;
  logic [3:0][3:0] slotMap;
  logic [3:0] outputDrive;
  logic bclkSync, lrSync, otSync;
  assign dataFormat = regFmt[7:6];
  assign portMode = regFmt[5:3];
  assign rateBand = regFmt[2:0];
  assign tdmPinSelect = regFrame[7];
  assign slotWidthCode = regFrame[6:5];
  assign wordIs16 = regFrame[4];
  assign frameShape = regFrame[3];
  assign bitOrder = regFrame[2];
  assign clocksPerChannel = regFrame[1];
  assign clockMasterSelect = regFrame[0];
  assign frameClockPolarity = regPower[7];
  assign dataChangeEdge = regPower[6];
  assign slotMap = {regMapHi[7:4], regMapHi[3:0], regMapLo[7:4], regMapLo[3:0]};
  assign outputDrive = regDrive[7:4];
  assign unusedSlotFloat = regDrive[3];
  assign bclkSync = syncB[0];
  assign lrSync = syncB[1];
  assign otSync = syncB[2];

  // block power and clock generator controls straight from the registers
  assign power.regulator = regPower[5];
  assign power.vref = regPower[4];
  assign power.converter = regPower[3:0];
  assign pll.refFrame = regClock[4];
  assign pll.ratioCode = regClock[2:0];
  // frame reference only usable in the 32 kHz to 192 kHz bands
  assign pll.refSupported = !regClock[4] ||
    (rateBand >= RATE_32_48 && rateBand <= RATE_128_192);
  // multiplier ratio; reserved codes give zero so the generator stays idle
  always_comb begin
    case (regClock[2:0])
      3'h0: pll.ratio = 10'h080;
      3'h1: pll.ratio = 10'h100;
      3'h2: pll.ratio = 10'h180;
      3'h3: pll.ratio = 10'h200;
      3'h4: pll.ratio = 10'h300;
      default: pll.ratio = 10'h000;
    endcase
  end

  // ***************************************************
  // helpers
  // ***************************************************
  // slot length in bit clocks for the current mode
  function automatic logic [5:0] slotLen(input logic [2:0] mode, input logic [1:0] sw,
                                         input logic cpc);
    logic [5:0] len;
    len = LEN_32;
    if (mode == MODE_STEREO) begin
      len = cpc ? LEN_16 : LEN_32;
    end else begin
      case (sw)
        SLOTW_24: len = LEN_24;
        SLOTW_16: len = LEN_16;
        default: len = LEN_32;
      endcase
    end
    return len;
  endfunction : slotLen

  // number of slots that exist in a mode
  function automatic logic [4:0] slotCount(input logic [2:0] mode);
    logic [4:0] n;
    case (mode)
      MODE_STEREO: n = SLOTS_4;
      MODE_TDM2: n = SLOTS_2;
      MODE_TDM4: n = SLOTS_4;
      MODE_TDM8: n = SLOTS_8;
      MODE_TDM16: n = SLOTS_16;
      default: n = 5'h00;
    endcase
    return n;
  endfunction : slotCount

  // drive decision and data bit for one line: {drive, bit}
  function automatic logic [1:0] lineBit(input logic [4:0] slot, input logic [5:0] sbit,
                                         input aso_samples_t buf_, input logic [5:0] len);
    logic hit;
    logic [1:0] ch;
    logic [5:0] wlen, start, pos, k;
    logic b;
    hit = 1'b0;
    ch = 2'h0;
    b = 1'b0;
    // walk from the top so the lowest channel claiming the slot wins
    for (int i = 3; i >= 0; i--) begin
      if (outputDrive[i] && {1'b0, slotMap[i]} == slot) begin
        hit = 1'b1;
        ch = 2'(i);
      end
    end
    if (slot >= slotCount(portMode)) begin
      hit = 1'b0;
    end
    if (dataFormat == FMT_RJ24) begin
      wlen = LEN_24;
    end else if (dataFormat == FMT_RJ16) begin
      wlen = LEN_16;
    end else begin
      wlen = wordIs16 ? LEN_16 : LEN_24;
    end
    case (dataFormat)
      FMT_I2S: start = 6'h01;
      FMT_LJ: start = 6'h00;
      default: start = (len > wlen) ? len - wlen : 6'h00;
    endcase
    pos = sbit - start;
    k = bitOrder ? wlen - 6'h01 - pos : pos;
    if (hit && sbit >= start && pos < wlen) begin
      b = buf_.smp[ch][5'(SAMPLE_W - 1) - k[4:0]];
    end
    return {hit, b};
  endfunction : lineBit

  // ***************************************************
  // pin and status synchronisers
  // ***************************************************
  // first stage feeds only the second; the third copy is the edge history
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncLast <= 3'h0;
    end else begin
      syncA <= {overTemp, frameClkIn, bitClkIn};
      syncB <= syncA;
      syncLast <= syncB;
    end
  end

  // ***************************************************
  // framing and serial data
  // ***************************************************
  logic [2:0] divCnt, next_divCnt;
  logic bclkGen, next_bclkGen, lrGen, next_lrGen, prevLr, next_prevLr;
  logic [9:0] mPos, next_mPos, frameLen;
  logic [4:0] slotIdx, next_slotIdx, slotA, slotB;
  logic [5:0] slotBit, next_slotBit, len;
  aso_samples_t smpBuf, next_smpBuf;
  logic outA, outB, oeA_n, oeB_n, next_outA, next_outB, next_oeA_n, next_oeB_n;
  logic next_frameSeen, chgEdge, curLr, firstLvl, pulseLvl, startLvl;
  logic frameStart, halfStart, stereo50;
  logic [1:0] resA, resB;

  always_comb begin
    next_divCnt = divCnt;
    next_bclkGen = bclkGen;
    next_lrGen = lrGen;
    next_prevLr = prevLr;
    next_mPos = mPos;
    next_slotIdx = slotIdx;
    next_slotBit = slotBit;
    next_smpBuf = smpBuf;
    next_outA = outA;
    next_outB = outB;
    next_oeA_n = oeA_n;
    next_oeB_n = oeB_n;
    next_frameSeen = frameSeen;
    len = slotLen(portMode, slotWidthCode, clocksPerChannel);
    frameLen = (portMode == MODE_STEREO) ? {3'h0, len, 1'b0} :
      10'(len * slotCount(portMode));
    firstLvl = frameClockPolarity;
    pulseLvl = !frameClockPolarity;
    startLvl = frameShape ? pulseLvl : firstLvl;
    stereo50 = (portMode == MODE_STEREO) && !frameShape;
    // master divides the system clock; slave follows the host's edges
    if (clockMasterSelect) begin
      chgEdge = (divCnt == BCLK_HALF_CYC - 3'h1) && (bclkGen != dataChangeEdge);
      next_divCnt = (divCnt == BCLK_HALF_CYC - 3'h1) ? 3'h0 : divCnt + 3'h1;
      if (divCnt == BCLK_HALF_CYC - 3'h1) begin
        next_bclkGen = !bclkGen;
      end
    end else begin
      chgEdge = (bclkSync != syncLast[0]) && (bclkSync == dataChangeEdge);
      next_divCnt = 3'h0;
    end
    if (clockMasterSelect && chgEdge) begin
      next_mPos = (mPos >= frameLen - 10'h001) ? 10'h000 : mPos + 10'h001;
      if (frameShape) begin
        next_lrGen = (next_mPos == 10'h000) ? pulseLvl : !pulseLvl;
      end else begin
        next_lrGen = (next_mPos < {1'b0, frameLen[9:1]}) ? firstLvl : !firstLvl;
      end
    end
    curLr = clockMasterSelect ? next_lrGen : lrSync;
    frameStart = chgEdge && curLr == startLvl && prevLr != startLvl;
    halfStart = chgEdge && stereo50 && curLr != firstLvl && prevLr == firstLvl;
    if (chgEdge) begin
      next_prevLr = curLr;
      if (frameStart) begin
        next_slotIdx = 5'h00;
        next_slotBit = 6'h00;
        next_frameSeen = 1'b1;
        for (int i = 0; i < 4; i++) begin
          // a powered-down converter sends silence
          next_smpBuf.smp[i] = power.converter[i] ? samples.smp[i] : '0;
        end
      end else if (halfStart) begin
        next_slotIdx = 5'h01;
        next_slotBit = 6'h00;
      end else if (!stereo50 && slotBit == len - 6'h01) begin
        next_slotIdx = (slotIdx == SLOT_NONE) ? SLOT_NONE : slotIdx + 5'h01;
        next_slotBit = 6'h00;
      end else if (slotBit != 6'h3F) begin
        next_slotBit = slotBit + 6'h01;
      end
    end
    // stereo pairs slots 3 and 4 on the second line; TDM4+ uses one chosen pin
    // the idle index must not wrap into a real slot, and stereo line A carries slots 1-2 only
    slotA = (portMode == MODE_STEREO && next_slotIdx >= STEREO_B_OFS) ? SLOT_NONE : next_slotIdx;
    slotB = (portMode == MODE_STEREO && next_slotIdx < STEREO_B_OFS) ?
      next_slotIdx + STEREO_B_OFS : SLOT_NONE;
    resA = lineBit(slotA, next_slotBit, next_smpBuf, len);
    resB = lineBit(slotB, next_slotBit, next_smpBuf, len);
    if (portMode >= MODE_TDM4 && tdmPinSelect) begin
      resB = resA;
      resA = 2'h0;
    end
    if (chgEdge) begin
      next_outA = resA[1] & resA[0];
      next_oeA_n = !resA[1] && unusedSlotFloat;
      next_outB = resB[1] & resB[0];
      next_oeB_n = !resB[1] && unusedSlotFloat;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 3'h0;
      bclkGen <= 1'b0;
      lrGen <= 1'b0;
      prevLr <= 1'b0;
      mPos <= 10'h000;
      slotIdx <= SLOT_NONE;
      slotBit <= 6'h00;
      smpBuf <= '0;
      outA <= 1'b0;
      outB <= 1'b0;
      oeA_n <= 1'b0;
      oeB_n <= 1'b0;
      frameSeen <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      bclkGen <= next_bclkGen;
      lrGen <= next_lrGen;
      prevLr <= next_prevLr;
      mPos <= next_mPos;
      slotIdx <= next_slotIdx;
      slotBit <= next_slotBit;
      smpBuf <= next_smpBuf;
      outA <= next_outA;
      outB <= next_outB;
      oeA_n <= next_oeA_n;
      oeB_n <= next_oeB_n;
      frameSeen <= next_frameSeen;
    end
  end

  // clock pins are driven only in master mode
  assign bitClkOut = bclkGen;
  assign frameClkOut = lrGen;
  assign bitClkOe_n = !clockMasterSelect;
  assign frameClkOe_n = !clockMasterSelect;
  assign serialOutA = outA;
  assign serialOutAOe_n = oeA_n;
  assign serialOutB = outB;
  assign serialOutBOe_n = oeB_n;

  // ***************************************************
  // AXI4-Lite slave
  // ***************************************************
  function automatic logic isMapped(input logic [7:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    return (idx == IDX_CLOCK_MULT) || (idx >= IDX_POWER_POL && idx <= IDX_DRIVE_THERMAL) ||
      (idx == IDX_PORT_STATUS);
  endfunction : isMapped

  // address and data are held separately so either may come first
  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready = !wHeld && !bValid;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rresp = rResp;
  assign s_axi_rdata = {24'h000000, rData};

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wLane0 = wLane0;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rResp = rResp;
    next_rData = rData;
    next_regClock = regClock;
    next_regPower = regPower;
    next_regFmt = regFmt;
    next_regFrame = regFrame;
    next_regMapLo = regMapLo;
    next_regMapHi = regMapHi;
    next_regDrive = regDrive;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata[7:0];
      next_wLane0 = s_axi_wstrb[0];
    end
    if (awHeld && wHeld) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (wLane0) begin
        case (awAddr[7:2])
          IDX_CLOCK_MULT: next_regClock = wData;
          IDX_POWER_POL: next_regPower = wData;
          IDX_FMT_MODE_RATE: next_regFmt = wData;
          IDX_FRAME_SLOT: next_regFrame = wData;
          IDX_MAP_LOW: next_regMapLo = wData;
          IDX_MAP_HIGH: next_regMapHi = wData;
          IDX_DRIVE_THERMAL: next_regDrive = wData & DRIVE_WR_MASK;
          default: next_regDrive = regDrive;
        endcase
      end
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr[7:2])
        IDX_CLOCK_MULT: next_rData = regClock & 8'h17; // lock status has no source here
        IDX_POWER_POL: next_rData = regPower;
        IDX_FMT_MODE_RATE: next_rData = regFmt;
        IDX_FRAME_SLOT: next_rData = regFrame;
        IDX_MAP_LOW: next_rData = regMapLo;
        IDX_MAP_HIGH: next_rData = regMapHi;
        IDX_DRIVE_THERMAL: next_rData = {regDrive[7:3], 2'h0, otSync};
        IDX_PORT_STATUS: next_rData = {5'h00, pll.refSupported, clockMasterSelect, frameSeen};
        default: next_rData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 8'h00;
      wLane0 <= 1'b0;
      bValid <= 1'b0;
      bResp <= RESP_OKAY;
      rValid <= 1'b0;
      rResp <= RESP_OKAY;
      rData <= 8'h00;
      regClock <= RST_CLOCK_MULT;
      regPower <= RST_POWER_POL;
      regFmt <= RST_FMT_MODE_RATE;
      regFrame <= RST_FRAME_SLOT;
      regMapLo <= RST_MAP_LOW;
      regMapHi <= RST_MAP_HIGH;
      regDrive <= RST_DRIVE_THERMAL;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wLane0 <= next_wLane0;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rResp <= next_rResp;
      rData <= next_rData;
      regClock <= next_regClock;
      regPower <= next_regPower;
      regFmt <= next_regFmt;
      regFrame <= next_regFrame;
      regMapLo <= next_regMapLo;
      regMapHi <= next_regMapHi;
      regDrive <= next_regDrive;
    end
  end
endmodule : aso_serial_port
`default_nettype wire

// ### aso_serial_port_sva.sv
// assertions on the serial output port pins and register bus
`timescale 1ns/100ps
`default_nettype none
module aso_serial_port_sva
  import aso_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock pins and generator controls
  input wire logic bitClkOut,
  input wire logic bitClkOe_n,
  input wire logic frameClkOe_n,
  input wire aso_pll_t pll,
  input wire logic [2:0] rateBand
);
  // reserved codes give no ratio
  localparam logic [9:0] RATIO [8] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300,
    10'h000, 10'h000, 10'h000};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_toggle;
    !bitClkOe_n && $changed(bitClkOut);
  endsequence
  property p_wr_lat;
    s_wtake |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer wrong");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ratio;
    pll.ratio == RATIO[pll.ratioCode];
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio mismatch");
  property p_ref;
    pll.refSupported == (!pll.refFrame || (rateBand >= 3'h2 && rateBand <= 3'h4));
  endproperty
  a_ref: assert property (p_ref) else $error("reference support wrong");
  property p_oe_pair;
    bitClkOe_n == frameClkOe_n;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock drive split");
  // half period of four system clocks gives the 400 ns bit clock
  property p_half;
    s_toggle |=> (!bitClkOe_n && $stable(bitClkOut))[*3] ##1 $changed(bitClkOut);
  endproperty
  a_half: assert property (p_half) else $error("bit clock period wrong");
endmodule : aso_serial_port_sva
bind aso_serial_port aso_serial_port_sva i_aso_serial_port_sva (.clk_sys, .rstn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .bitClkOut, .bitClkOe_n, .frameClkOe_n, .pll, .rateBand);
`default_nettype wire

// ### aso_host_model.sv
// host serial port model: makes bit and frame clocks, captures data
`timescale 1ns/100ps
`default_nettype none
module aso_host_model (
  // clocks to the device
  output logic bitClk,
  output logic frameClk,
  // data from the device
  input wire logic dataA,
  input wire logic dataB,
  input wire logic oeA_n
);
  logic [63:0] capA, capB, capOe;
  // clocks rest high between frames
  initial begin
    bitClk = 1'b1;
    frameClk = 1'b1;
  end
  // offset keeps pin edges off the system clock; sampling late in the bit gives margin
  task run(input int n);
    #17;
    repeat (n) for (int i = 0; i < 64; i++) begin
      bitClk = 1'b0;
      frameClk = i >= 32;
      #200 bitClk = 1'b1;
      #200 capA = {capA[62:0], dataA};
      capB = {capB[62:0], dataB};
      capOe = {capOe[62:0], oeA_n};
    end
  endtask : run
endmodule : aso_host_model
`default_nettype wire

// ### tb_aso_serial_port.sv
// self-checking bench for the converter serial output port
`timescale 1ns/100ps
`default_nettype none
module tb_aso_serial_port;
  import aso_pkg::*;
  typedef struct packed {
    logic [7:0] fmt, frm, map, drv;
    logic [3:0] drop;
  } aso_row_t;
  // stereo link cases: format, frame control, low map, drive, channels left out
  localparam aso_row_t ROWS [9] = '{'{8'h42, 8'h00, 8'h10, 8'hF0, 4'h0},
    '{8'h42, 8'h04, 8'h10, 8'hF0, 4'h0}, '{8'h02, 8'h00, 8'h10, 8'hF0, 4'h0},
    '{8'h42, 8'h00, 8'h80, 8'hF0, 4'h2}, '{8'h42, 8'h00, 8'h00, 8'hF0, 4'h2},
    '{8'h42, 8'h00, 8'h10, 8'h70, 4'h8}, '{8'h42, 8'h00, 8'h10, 8'hE8, 4'h1},
    '{8'h82, 8'h00, 8'h10, 8'hF0, 4'h0}, '{8'h42, 8'h10, 8'h10, 8'hF0, 4'h0}};
  localparam logic [9:0] RATIO [8] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300,
    10'h000, 10'h000, 10'h000};
  localparam logic [5:0] RIDX [8] = '{IDX_CLOCK_MULT, IDX_POWER_POL, IDX_FMT_MODE_RATE,
    IDX_FRAME_SLOT, IDX_MAP_LOW, IDX_MAP_HIGH, IDX_DRIVE_THERMAL, 6'h02};
  localparam logic [7:0] RVAL [8] = '{RST_CLOCK_MULT, RST_POWER_POL, RST_FMT_MODE_RATE,
    RST_FRAME_SLOT, RST_MAP_LOW, RST_MAP_HIGH, RST_DRIVE_THERMAL, 8'h00};
  logic clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, overTemp, bitClkIn, bitClkOut, bitClkOe_n, frameClkIn;
  logic frameClkOut, frameClkOe_n, serialOutA, serialOutAOe_n, serialOutB, serialOutBOe_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rdv;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] rateBand;
  logic [63:0] t0, oe;
  aso_samples_t samples;
  aso_power_t power;
  aso_pll_t pll;
  int fails, checked, cyc;
  aso_serial_port i_aso_serial_port (.*);
  aso_host_model i_aso_host_model (.bitClk(bitClkIn), .frameClk(frameClkIn),
    .dataA(serialOutA), .dataB(serialOutB), .oeA_n(serialOutAOe_n | serialOutBOe_n));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard, well above the roughly 11500 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 32'h7530) begin
      fails++;
      wrap_up();
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bready and rready stay high, so only the request side moves
  task wr(input logic [5:0] i, input logic [7:0] d);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr
  task rd(input logic [5:0] i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask : rd
  // expected 32-bit slot of one channel, placed in its slot per the row format (I2S, left justified or 24-bit right justified)
  function automatic logic [31:0] slot(input int ch, input aso_row_t w);
    logic [23:0] s;
    logic [31:0] v;
    s = samples.smp[ch];
    if (w.frm[4]) s[7:0] = 8'h00;
    if (w.frm[2]) s = {<<{s}};
    v = {s, 8'h00};
    if (w.fmt[7:6] == FMT_I2S) v = v >> 1;
    if (w.fmt[7:6] == FMT_RJ24) v = v >> 8;
    return w.drop[ch] ? 32'h00000000 : v;
  endfunction : slot
  task wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, overTemp} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    samples = {24'h81F00D, 24'hC0FFEE, 24'h5A3C1E, 24'hA5C3E1};
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk(power, 6'h3F);
    for (int i = 0; i < 8; i++) begin
      rd(RIDX[i]);
      chk({rsp, rdv}, {(i == 7 ? RESP_SLVERR : RESP_OKAY), RVAL[i]});
    end
    wr(IDX_POWER_POL, 8'h15);
    chk({rsp, power}, {RESP_OKAY, 6'h15});
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CLOCK_MULT, 8'(c));
      chk(pll.ratio, RATIO[c]);
    end
    wr(IDX_CLOCK_MULT, 8'h14);
    wr(IDX_FMT_MODE_RATE, 8'h00);
    chk({pll.refSupported, rateBand}, 4'h0);
    wr(IDX_POWER_POL, 8'h3F);
    $display("register tests done");
    for (int r = 0; r < 9; r++) begin
      wr(IDX_FMT_MODE_RATE, ROWS[r].fmt);
      wr(IDX_FRAME_SLOT, ROWS[r].frm);
      wr(IDX_MAP_LOW, ROWS[r].map);
      wr(IDX_DRIVE_THERMAL, ROWS[r].drv);
      i_aso_host_model.run(2);
      @(posedge clk_sys);
      oe = {{32{ROWS[r].drv[3] & ROWS[r].drop[0]}}, {32{ROWS[r].drv[3] & ROWS[r].drop[1]}}};
      chk(i_aso_host_model.capA & ~oe, {slot(0, ROWS[r]), slot(1, ROWS[r])});
      chk(i_aso_host_model.capB, {slot(2, ROWS[r]), slot(3, ROWS[r])});
      chk(i_aso_host_model.capOe, oe);
      $display("link row %0d done", r);
    end
    for (int k = 0; k < 2; k++) begin
      wr(IDX_FRAME_SLOT, {6'h00, k[0], 1'b1});
      chk(bitClkOe_n | frameClkOe_n, 1'b0);
      repeat (2) @(posedge frameClkOut);
      t0 = $time;
      @(posedge frameClkOut);
      chk(($time - t0) / SYS_PERIOD_NS, k ? 64'h100 : 64'h200);
    end
    $display("master tests done");
    wrap_up();
  end
endmodule : tb_aso_serial_port
`default_nettype wire
